/* File: design/pwrsd_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module pwrsd_filter
    import pwrsd_pkg::*;
#(
    parameter int CYC = UVLO_FILT_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic d,
    output var  logic q
);

    localparam int CW = $clog2(CYC + 1);

    logic [CW-1:0] cnt;
    wire           differs = (d != q);
    wire           settled = (cnt == CW'(CYC - 1));

    // the output only follows once the input has held its new level for the whole window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            q   <= 1'b1;
        end else if (ce) begin
            if (!differs) begin
                cnt <= '0;
            end else if (settled) begin
                cnt <= '0;
                q   <= d;
            end else begin
                cnt <= cnt + CW'(1);
            end
        end
    end

endmodule
`default_nettype wire

/* File: design/pwrsd_pkg.sv */
package pwrsd_pkg;

    // clock and synchroniser depth
    localparam int CLK_FREQ_MHZ = 100;
    localparam int SYNC_STAGES  = 2;

    // enable wake-up: longest time, rounded down, less the input synchroniser latency
    localparam int EN_WAKE_MAX_US = 10;
    localparam int EN_WAKE_CYC    = EN_WAKE_MAX_US * CLK_FREQ_MHZ - SYNC_STAGES;
    localparam int WAKE_W         = $clog2(EN_WAKE_CYC + 1);

    // break time between one switch going off and the other going on (least time, rounded up)
    localparam int DEAD_TIME_NS = 20;
    localparam int DEAD_CYC     = (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEAD_W       = $clog2(DEAD_CYC + 1);

    // supply undervoltage glitch filter (least time, rounded up)
    localparam int UVLO_FILT_NS  = 500;
    localparam int UVLO_FILT_CYC = (UVLO_FILT_NS * CLK_FREQ_MHZ + 999) / 1000;

    // fault counts in pwm cycles
    localparam logic [2:0] PHASE_FLT_CYCLES = 3'h7;
    localparam logic [3:0] OCP_FLT_EVENTS   = 4'hA;
    localparam logic [1:0] OCP_CLEAR_CYCLES = 2'h3;

    // reset values
    localparam logic FAULT_RESET = 1'b0;

    typedef enum logic [1:0] {
        PWRSD_PWM_LOW,
        PWRSD_PWM_HIGH,
        PWRSD_PWM_TRI
    } pwrsd_pwm_t;

    typedef enum logic [1:0] {
        PWRSD_GD_OFF,
        PWRSD_GD_HS,
        PWRSD_GD_LS
    } pwrsd_gate_t;

    // three-level decode from the two threshold comparators
    function automatic pwrsd_pwm_t pwrsd_decode(input logic above_high, input logic below_low);
        if (above_high) begin
            return PWRSD_PWM_HIGH;
        end else if (below_low) begin
            return PWRSD_PWM_LOW;
        end else begin
            return PWRSD_PWM_TRI;
        end
    endfunction

endpackage

/* File: design/pwrsd_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - pwm high: low side off, high side on
// - pwm low: high side off before low on
// - tri-state or floating pwm: both switches off
// - enable low: deep sleep, drive stops now
// - deep sleep shorts current report to reference
// - active within 10 us of enable rising
// - over 140 C: fault high, switches off
// - fault held until below 120 C, resume
// - phase check at pwm rise with low on
// - seven phase-fault cycles raise fault, clean cycle clears
// - phase fault never blocks switching
// - filtered supply undervoltage: ignore pwm, both off
// - undervoltage weakly pulls fault low, and report too outside deep sleep
// - release only when both supplies recovered
// - bootstrap undervoltage drives fault high
// - overcurrent compare every cycle, fixed or set
// - overcurrent truncates the present high pulse
// - ten severe overcurrent events raise fault
// - three clean cycles clear overcurrent fault
// - fault pin actively driven high, wired bus
module pwrsd_stage
    import pwrsd_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic CE,
    input  wire logic PWM_ABOVE_HIGH,
    input  wire logic PWM_BELOW_LOW,
    input  wire logic EN,
    input  wire logic TEMP_ABOVE_RISE,
    input  wire logic TEMP_BELOW_FALL,
    input  wire logic SW_ABOVE_SHORT,
    input  wire logic VCC_UNDERVOLT,
    input  wire logic VDRV_UNDERVOLT,
    input  wire logic BOOT_UNDERVOLT,
    input  wire logic OVERCURRENT_SET_PIN_OPEN,
    input  wire logic OVER_CURRENT_PROTECT_TRIP,
    input  wire logic OVER_CURRENT_PROTECT_SEVERE,
    output var  logic HS_GATE_ON,
    output var  logic LS_GATE_ON,
    output var  logic TEMP_FAULT_PIN_O,
    output var  logic TEMP_FAULT_PIN_OE,
    output var  logic TEMP_FAULT_PIN_WEAK_PD,
    output var  logic CURRENT_REPORT_OUT_WEAK_PD,
    output var  logic CURRENT_REPORT_OUT_TO_REFERENCE,
    output var  logic OCP_THRESHOLD_FIXED,
    output var  logic DEEP_SLEEP,
    output var  logic READY
);

    localparam int NSYNC = 12;

    // input synchronisers
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;

    assign raw_in = {PWM_ABOVE_HIGH, PWM_BELOW_LOW, EN, TEMP_ABOVE_RISE, TEMP_BELOW_FALL,
                     SW_ABOVE_SHORT, VCC_UNDERVOLT, VDRV_UNDERVOLT, BOOT_UNDERVOLT,
                     OVERCURRENT_SET_PIN_OPEN, OVER_CURRENT_PROTECT_TRIP, OVER_CURRENT_PROTECT_SEVERE};

    pwrsd_sync #(
        .W (NSYNC)
    ) u_sync (
        .clk  (CLK),
        .rstn (RSTN),
        .ce   (CE),
        .d    (raw_in),
        .q    (sync_in)
    );

    wire pwm_hi_s   = sync_in[11];
    wire pwm_lo_s   = sync_in[10];
    wire en_s       = sync_in[9];
    wire t_rise_s   = sync_in[8];
    wire t_fall_s   = sync_in[7];
    wire sw_short_s = sync_in[6];
    wire vcc_uv_s   = sync_in[5];
    wire vdrv_uv_s  = sync_in[4];
    wire boot_uv_s  = sync_in[3];
    wire overcurrent_set_pin_op_s = sync_in[2];
    wire oc_trip_s  = sync_in[1];
    wire oc_sev_s   = sync_in[0];

    // supply undervoltage
    logic vcc_uv_f;
    logic vdrv_uv_f;

    pwrsd_filter #(
        .CYC (UVLO_FILT_CYC)
    ) u_vcc_filt (
        .clk  (CLK),
        .rstn (RSTN),
        .ce   (CE),
        .d    (vcc_uv_s),
        .q    (vcc_uv_f)
    );

    pwrsd_filter #(
        .CYC (UVLO_FILT_CYC)
    ) u_vdrv_filt (
        .clk  (CLK),
        .rstn (RSTN),
        .ce   (CE),
        .d    (vdrv_uv_s),
        .q    (vdrv_uv_f)
    );

    // lockout holds until both supplies are good again; filters start in lockout at reset
    wire uvlo = vcc_uv_f | vdrv_uv_f;

    // pwm decode and edges
    pwrsd_pwm_t pwm_now;
    pwrsd_pwm_t pwm_prev;

    assign pwm_now = pwrsd_decode(pwm_hi_s, pwm_lo_s);

    wire pwm_rise = (pwm_now == PWRSD_PWM_HIGH) && (pwm_prev != PWRSD_PWM_HIGH);
    wire pwm_fall = (pwm_now != PWRSD_PWM_HIGH) && (pwm_prev == PWRSD_PWM_HIGH);

    // enable and wake-up
    logic [WAKE_W-1:0] wake_cnt;
    logic              ready;

    wire sleep     = !en_s;
    wire wake_done = (wake_cnt == WAKE_W'(EN_WAKE_CYC - 1));

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_cnt <= '0;
            ready    <= 1'b0;
        end else if (CE) begin
            if (sleep) begin
                wake_cnt <= '0;
                ready    <= 1'b0;
            end else if (!ready) begin
                wake_cnt <= wake_done ? wake_cnt : wake_cnt + WAKE_W'(1);
                ready    <= wake_done;
            end
        end
    end

    // over-temperature
    logic otp;

    // rising threshold wins if both comparators claim at once
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            otp <= FAULT_RESET;
        end else if (CE) begin
            if (t_rise_s) begin
                otp <= 1'b1;
            end else if (t_fall_s) begin
                otp <= 1'b0;
            end
        end
    end

    // gate drive
    pwrsd_gate_t       gd_state;
    pwrsd_gate_t       next_gd_state;
    logic [DEAD_W-1:0] dead_cnt;
    logic              oc_cut;

    // phase fault and overcurrent flags are deliberately absent here; sleep cuts before ready drops
    wire drive_allowed = ready && !sleep && !uvlo && !otp;
    wire want_hs       = drive_allowed && (pwm_now == PWRSD_PWM_HIGH) && !oc_cut;
    wire want_ls       = drive_allowed && (pwm_now == PWRSD_PWM_LOW);
    wire dead_done     = (dead_cnt == DEAD_W'(DEAD_CYC));

    always_comb begin
        next_gd_state = gd_state;
        unique case (gd_state)
            PWRSD_GD_OFF: begin
                if (want_hs && dead_done) begin
                    next_gd_state = PWRSD_GD_HS;
                end else if (want_ls && dead_done) begin
                    next_gd_state = PWRSD_GD_LS;
                end
            end
            PWRSD_GD_HS: begin
                if (!want_hs) begin
                    next_gd_state = PWRSD_GD_OFF;
                end
            end
            PWRSD_GD_LS: begin
                if (!want_ls) begin
                    next_gd_state = PWRSD_GD_OFF;
                end
            end
        endcase
    end

    // tri-state requests from the controller land in the off state
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gd_state <= PWRSD_GD_OFF;
            dead_cnt <= '0;
        end else if (CE) begin
            gd_state <= next_gd_state;
            if (next_gd_state != PWRSD_GD_OFF) begin
                dead_cnt <= '0;
            end else if (!dead_done) begin
                dead_cnt <= dead_cnt + DEAD_W'(1);
            end
        end
    end

    // gate outputs decoded from the state register; sleep and lockout cut them at once
    assign HS_GATE_ON = (gd_state == PWRSD_GD_HS) && drive_allowed && !oc_cut;
    assign LS_GATE_ON = (gd_state == PWRSD_GD_LS) && drive_allowed;

    // phase fault
    logic [2:0] ph_cnt;
    logic       ph_flag;

    wire ph_check = pwm_rise && (gd_state == PWRSD_GD_LS);
    wire ph_bad   = ph_check && sw_short_s;
    wire ph_sat   = (ph_cnt == PHASE_FLT_CYCLES);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ph_cnt  <= '0;
            ph_flag <= FAULT_RESET;
        end else if (CE) begin
            if (sleep) begin
                ph_cnt  <= '0;
                ph_flag <= 1'b0;
            end else if (ph_bad) begin
                ph_cnt  <= ph_sat ? ph_cnt : ph_cnt + 3'h1;
                ph_flag <= ph_flag || (ph_cnt == PHASE_FLT_CYCLES - 3'h1);
            end else if (ph_check) begin
                ph_cnt  <= '0;
                ph_flag <= 1'b0;
            end
        end
    end

    // overcurrent
    logic [3:0] sev_cnt;
    logic [1:0] clean_cnt;
    logic       sev_seen;
    logic       oc_seen;
    logic       oc_flag;
    logic       ocp_fixed;

    wire in_high   = (pwm_now == PWRSD_PWM_HIGH);
    wire oc_now    = in_high && oc_trip_s;
    wire sev_now   = in_high && oc_sev_s;
    wire sev_sat   = (sev_cnt == OCP_FLT_EVENTS);
    wire clean_sat = (clean_cnt == OCP_CLEAR_CYCLES);

    // truncation lasts to the end of the pulse; the next rise starts clean
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            oc_cut   <= 1'b0;
            oc_seen  <= 1'b0;
            sev_seen <= 1'b0;
        end else if (CE) begin
            if (pwm_fall || sleep) begin
                oc_cut   <= 1'b0;
                oc_seen  <= 1'b0;
                sev_seen <= 1'b0;
            end else begin
                oc_cut   <= oc_cut || oc_now;
                oc_seen  <= oc_seen || oc_now;
                sev_seen <= sev_seen || sev_now;
            end
        end
    end

    // a non-severe trip breaks the severe run without counting as clean
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sev_cnt   <= '0;
            clean_cnt <= '0;
            oc_flag   <= FAULT_RESET;
        end else if (CE) begin
            if (sleep) begin
                sev_cnt   <= '0;
                clean_cnt <= '0;
                oc_flag   <= 1'b0;
            end else if (pwm_fall) begin
                if (sev_seen || sev_now) begin
                    sev_cnt   <= sev_sat ? sev_cnt : sev_cnt + 4'h1;
                    clean_cnt <= '0;
                    oc_flag   <= oc_flag || (sev_cnt == OCP_FLT_EVENTS - 4'h1);
                end else if (oc_seen || oc_now) begin
                    sev_cnt   <= '0;
                    clean_cnt <= '0;
                end else begin
                    sev_cnt   <= '0;
                    clean_cnt <= clean_sat ? clean_cnt : clean_cnt + 2'h1;
                    if (clean_cnt == OCP_CLEAR_CYCLES - 2'h1) begin
                        oc_flag <= 1'b0;
                    end
                end
            end
        end
    end

    // threshold source: fixed level when the set pin is open or tied high
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ocp_fixed <= 1'b1;
        end else if (CE) begin
            ocp_fixed <= overcurrent_set_pin_op_s;
        end
    end

    assign OCP_THRESHOLD_FIXED = ocp_fixed;

    // fault pin and current report
    wire any_fault = otp || ph_flag || boot_uv_s || oc_flag;

    // the pin drives high only for a fault and otherwise leaves the bus to the temperature level
    assign TEMP_FAULT_PIN_O                = any_fault && !uvlo;
    assign TEMP_FAULT_PIN_OE               = any_fault && !uvlo;
    assign TEMP_FAULT_PIN_WEAK_PD          = uvlo;
    assign CURRENT_REPORT_OUT_WEAK_PD      = uvlo && !sleep;
    assign CURRENT_REPORT_OUT_TO_REFERENCE = sleep;
    assign DEEP_SLEEP                      = sleep;
    assign READY                           = ready;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pwm_prev <= PWRSD_PWM_TRI;
        end else if (CE) begin
            pwm_prev <= pwm_now;
        end
    end

endmodule
`default_nettype wire

/* File: design/pwrsd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pwrsd_sync
    import pwrsd_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule
`default_nettype wire

/* File: verification/pwrsd_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwrsd_ctrl_model
    import pwrsd_pkg::*;
(
    input  wire pwrsd_pwm_t level,
    output wire logic       above_high,
    output wire logic       below_low
);
    // a tri-state request leaves both comparators quiet; braking and diode emulation use it
    assign above_high = (level == PWRSD_PWM_HIGH);
    assign below_low  = (level == PWRSD_PWM_LOW);
endmodule
`default_nettype wire

/* File: verification/pwrsd_stage_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pwrsd_stage_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic EN,
    input wire logic TEMP_ABOVE_RISE,
    input wire logic BOOT_UNDERVOLT,
    input wire logic OVER_CURRENT_PROTECT_TRIP,
    input wire logic HS_GATE_ON,
    input wire logic LS_GATE_ON,
    input wire logic TEMP_FAULT_PIN_O,
    input wire logic TEMP_FAULT_PIN_OE,
    input wire logic TEMP_FAULT_PIN_WEAK_PD,
    input wire logic CURRENT_REPORT_OUT_WEAK_PD,
    input wire logic CURRENT_REPORT_OUT_TO_REFERENCE,
    input wire logic DEEP_SLEEP,
    input wire logic READY
);
    logic [10:0] en_wait;
    // counted from the raw pin, so the sync edges fall inside the bound
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            en_wait <= 11'h000;
        end else begin
            en_wait <= (EN && !READY) ? en_wait + 11'h001 : 11'h000;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence hs_gap; !HS_GATE_ON ##1 !HS_GATE_ON; endsequence
    sequence ls_gap; !LS_GATE_ON ##1 !LS_GATE_ON; endsequence
    sequence boot_held; BOOT_UNDERVOLT [*5] ##0 !TEMP_FAULT_PIN_WEAK_PD; endsequence
    sequence hot_held; TEMP_ABOVE_RISE [*5] ##0 !TEMP_FAULT_PIN_WEAK_PD; endsequence
    a_gates_apart: assert property (!(HS_GATE_ON && LS_GATE_ON))
        else $error("both switches on");
    a_hs_dead_gap: assert property ($fell(LS_GATE_ON) |-> hs_gap)
        else $error("high side on inside dead time");
    a_ls_dead_gap: assert property ($fell(HS_GATE_ON) |-> ls_gap)
        else $error("low side on inside dead time");
    a_sleep_no_drive: assert property (DEEP_SLEEP |-> !HS_GATE_ON && !LS_GATE_ON)
        else $error("gate drive in deep sleep");
    a_sleep_short: assert property (CURRENT_REPORT_OUT_TO_REFERENCE == DEEP_SLEEP)
        else $error("report short does not follow sleep");
    a_wake_bound: assert property (en_wait <= 11'h3E8)
        else $error("wake took too long");
    a_lockout_quiet: assert property (TEMP_FAULT_PIN_WEAK_PD |->
        !HS_GATE_ON && !LS_GATE_ON && !TEMP_FAULT_PIN_OE)
        else $error("activity during lockout");
    a_report_pull: assert property (CURRENT_REPORT_OUT_WEAK_PD == (TEMP_FAULT_PIN_WEAK_PD && !DEEP_SLEEP))
        else $error("report pulldown wrong");
    a_fault_drive: assert property (TEMP_FAULT_PIN_OE |-> TEMP_FAULT_PIN_O)
        else $error("fault pin enabled but not high");
    a_boot_flag: assert property (boot_held |-> TEMP_FAULT_PIN_OE)
        else $error("bootstrap fault not flagged");
    a_hot_stop: assert property (hot_held |-> TEMP_FAULT_PIN_OE && !HS_GATE_ON && !LS_GATE_ON)
        else $error("over temperature not handled");
    a_trip_cut: assert property (OVER_CURRENT_PROTECT_TRIP [*5] |-> !HS_GATE_ON)
        else $error("high pulse not truncated");
endmodule
bind pwrsd_stage pwrsd_stage_chk u_chk (
    .CLK(CLK), .RSTN(RSTN), .EN(EN), .TEMP_ABOVE_RISE(TEMP_ABOVE_RISE), .BOOT_UNDERVOLT(BOOT_UNDERVOLT),
    .OVER_CURRENT_PROTECT_TRIP(OVER_CURRENT_PROTECT_TRIP), .HS_GATE_ON(HS_GATE_ON), .LS_GATE_ON(LS_GATE_ON),
    .TEMP_FAULT_PIN_O(TEMP_FAULT_PIN_O), .TEMP_FAULT_PIN_OE(TEMP_FAULT_PIN_OE),
    .TEMP_FAULT_PIN_WEAK_PD(TEMP_FAULT_PIN_WEAK_PD), .CURRENT_REPORT_OUT_WEAK_PD(CURRENT_REPORT_OUT_WEAK_PD),
    .CURRENT_REPORT_OUT_TO_REFERENCE(CURRENT_REPORT_OUT_TO_REFERENCE), .DEEP_SLEEP(DEEP_SLEEP), .READY(READY)
);
`default_nettype wire

/* File: verification/pwrsd_stage_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pwrsd_stage_test
    import pwrsd_pkg::*;
;
    localparam logic [8:0] M_HS = 9'h100, M_LS = 9'h080, M_OE = 9'h040, M_PD = 9'h020, M_RPD = 9'h010;
    localparam logic [8:0] M_REF = 9'h008, M_FIX = 9'h004, M_SLP = 9'h002, M_RDY = 9'h001;
    typedef struct packed {
        logic [8:0] val;
        logic [8:0] mask;
    } pwrsd_note_t;
    pwrsd_note_t notes[$];
    pwrsd_note_t cur;
    int          miscompares = 0;
    int          n_compared  = 0;
    logic [16:0] seed;
    pwrsd_pwm_t  level, lv;
    logic        clk, rstn, ce, en, t_rise, t_fall, sw_hi, vcc_uv, vdrv_uv, boot_uv, set_open, trip, severe;
    logic        ah, bl, hs, ls, flt_o, flt_oe, flt_pd, rep_pd, rep_ref, ocp_fix, sleep, ready;
    wire  logic [8:0] obs = {hs, ls, flt_oe, flt_pd, rep_pd, rep_ref, ocp_fix, sleep, ready};

    pwrsd_ctrl_model ctrl_u (.level(level), .above_high(ah), .below_low(bl));
    pwrsd_stage dut_u (
        .CLK(clk), .RSTN(rstn), .CE(ce), .PWM_ABOVE_HIGH(ah), .PWM_BELOW_LOW(bl), .EN(en),
        .TEMP_ABOVE_RISE(t_rise), .TEMP_BELOW_FALL(t_fall), .SW_ABOVE_SHORT(sw_hi),
        .VCC_UNDERVOLT(vcc_uv), .VDRV_UNDERVOLT(vdrv_uv), .BOOT_UNDERVOLT(boot_uv),
        .OVERCURRENT_SET_PIN_OPEN(set_open), .OVER_CURRENT_PROTECT_TRIP(trip),
        .OVER_CURRENT_PROTECT_SEVERE(severe), .HS_GATE_ON(hs), .LS_GATE_ON(ls),
        .TEMP_FAULT_PIN_O(flt_o), .TEMP_FAULT_PIN_OE(flt_oe), .TEMP_FAULT_PIN_WEAK_PD(flt_pd),
        .CURRENT_REPORT_OUT_WEAK_PD(rep_pd), .CURRENT_REPORT_OUT_TO_REFERENCE(rep_ref),
        .OCP_THRESHOLD_FIXED(ocp_fix), .DEEP_SLEEP(sleep), .READY(ready)
    );

    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: outputs %b, expected %b", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic note(input logic [8:0] val, input logic [8:0] mask);
        notes.push_back({val & mask, mask});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pwm(input pwrsd_pwm_t l, input int n);
        level <= l;
        cyc(n);
    endtask

    // outputs are settled by the falling edge, so every queued note is judged there
    always @(negedge clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            check(obs & cur.mask, cur.val);
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        cyc(20000);
        miscompares++;
        close_out();
    end

    initial begin
        {rstn, en, t_rise, sw_hi, vcc_uv, vdrv_uv, boot_uv, set_open, trip, severe} = '0;
        ce = 1'b1;
        t_fall = 1'b1;
        level = PWRSD_PWM_TRI;
        seed = 17'h166C9;
        cyc(6);
        note(M_PD | M_REF | M_SLP, ~M_FIX);
        rstn <= 1'b1;
        cyc(1);
        en <= 1'b1;
        cyc(1005);
        note(M_RDY, M_RDY | M_PD | M_RPD | M_REF | M_SLP | M_HS | M_LS);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_next(seed);
            lv = pwrsd_pwm_t'(seed[1:0] % 2'h3);
            pwm(lv, 10);
            note({lv == PWRSD_PWM_HIGH, lv == PWRSD_PWM_LOW, 7'h00}, M_HS | M_LS);
        end
        sw_hi <= 1'b1;
        for (int i = 1; i <= 7; i++) begin
            pwm(PWRSD_PWM_LOW, 10);
            pwm(PWRSD_PWM_HIGH, 10);
            note({2'b10, i >= 7, 6'h00}, M_HS | M_LS | M_OE);
        end
        sw_hi <= 1'b0;
        pwm(PWRSD_PWM_LOW, 10);
        pwm(PWRSD_PWM_HIGH, 10);
        note(M_HS, M_HS | M_OE);
        trip <= 1'b1;
        pwm(PWRSD_PWM_LOW, 10);
        pwm(PWRSD_PWM_HIGH, 10);
        note(9'h000, M_HS);
        severe <= 1'b1;
        for (int i = 1; i <= 10; i++) begin
            pwm(PWRSD_PWM_HIGH, 10);
            pwm(PWRSD_PWM_LOW, 10);
            note({2'b01, i >= 10, 6'h00}, M_HS | M_LS | M_OE);
        end
        trip <= 1'b0;
        severe <= 1'b0;
        for (int i = 1; i <= 3; i++) begin
            pwm(PWRSD_PWM_HIGH, 10);
            pwm(PWRSD_PWM_LOW, 10);
            note({2'b01, i < 3, 6'h00}, M_LS | M_OE);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            set_open <= seed[0];
            cyc(5);
            note({6'h00, seed[0], 2'b00}, M_FIX);
        end
        // a frozen clock enable holds every output, the pwm decode included
        ce <= 1'b0;
        level <= PWRSD_PWM_HIGH;
        cyc(8);
        note(M_LS, M_HS | M_LS);
        ce <= 1'b1;
        level <= PWRSD_PWM_LOW;
        cyc(4);
        boot_uv <= 1'b1;
        cyc(6);
        note(M_OE | M_LS, M_OE | M_LS);
        boot_uv <= 1'b0;
        pwm(PWRSD_PWM_HIGH, 10);
        note(M_HS, M_OE | M_HS);
        t_rise <= 1'b1;
        t_fall <= 1'b0;
        cyc(6);
        note(M_OE, M_OE | M_HS | M_LS);
        t_rise <= 1'b0;
        cyc(20);
        note(M_OE, M_OE | M_HS);
        t_fall <= 1'b1;
        cyc(8);
        note(M_HS, M_OE | M_HS);
        // a short dip must be filtered out, so switching carries on
        vdrv_uv <= 1'b1;
        cyc(20);
        vdrv_uv <= 1'b0;
        cyc(5);
        note(M_HS, M_HS | M_PD);
        vdrv_uv <= 1'b1;
        boot_uv <= 1'b1;
        cyc(60);
        note(M_PD | M_RPD, M_HS | M_LS | M_OE | M_PD | M_RPD);
        vcc_uv <= 1'b1;
        vdrv_uv <= 1'b0;
        cyc(60);
        note(M_PD | M_RPD, M_HS | M_LS | M_OE | M_PD | M_RPD);
        vcc_uv <= 1'b0;
        boot_uv <= 1'b0;
        cyc(60);
        note(M_HS, M_HS | M_PD | M_RPD);
        en <= 1'b0;
        cyc(5);
        note(M_REF | M_SLP, M_HS | M_LS | M_REF | M_SLP | M_RPD);
        en <= 1'b1;
        cyc(1005);
        note(M_RDY | M_HS, M_RDY | M_HS | M_SLP | M_REF);
        cyc(2);
        close_out();
    end
endmodule
`default_nettype wire
